// ===== rtl/lwpr_core.sv
// LPDDR write capture, precharge, refresh and power-down core
`timescale 1ns/10ps
module lwpr_core #(
  parameter int DQ_W = 16,
  parameter int DM_W = 2,
  parameter int ADDR_W = 13,
  parameter int COL_W = 9,
  parameter int ROW_W = 13,
  parameter int BURST_LEN = lwpr_pkg::BURST_LEN,
  parameter int CNT_W = 8,
  parameter int REFI_CYC = lwpr_pkg::REFI_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [1:0] ba,
  input wire logic dqs_clk,
  input wire logic [DQ_W-1:0] dq_in,
  input wire logic [DM_W-1:0] dm,
  output logic dq_oe_n,
  output logic arr_we,
  output logic [1:0] arr_bank,
  output logic [COL_W-1:0] arr_col,
  output logic [2*DQ_W-1:0] arr_data,
  output logic [2*DM_W-1:0] arr_byte_en,
  output logic [3:0] bank_open,
  output logic [3:0] bank_prechg,
  output logic ref_pulse,
  output logic [ROW_W-1:0] ref_row,
  output logic in_sref,
  output logic pdn_pre,
  output logic pdn_act,
  output logic in_buf_en,
  output logic int_clk_en,
  output logic exit_busy
);
  localparam int SL = BURST_LEN / 2;
  localparam int PW = 2 * (DQ_W + DM_W);
  localparam int TMR_W = $clog2(REFI_CYC + 1);
  localparam int RP_A = lwpr_pkg::RP_CYC;

  function automatic logic [1:0] lwpr_gray(input logic [1:0] b);
    return b ^ (b >> 1);
  endfunction

  // Strobe domain: rising element held until the falling edge
  logic [DQ_W-1:0] rise_d_r;
  logic [DM_W-1:0] rise_m_r;
  logic [PW-1:0] cap_mem [4];
  logic [1:0] wb_r;
  logic [1:0] wg_r;

  // Capture element on each rising strobe edge
  always_ff @(posedge dqs_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_d_r <= '0;
      rise_m_r <= '0;
    end else begin
      rise_d_r <= dq_in;
      rise_m_r <= dm;
    end
  end

  // Falling edge completes a pair into the crossing slots
  always_ff @(negedge dqs_clk) begin
    cap_mem[wb_r] <= {dm, dq_in, rise_m_r, rise_d_r};
  end

  // Gray write pointer moves after its slot is loaded
  always_ff @(negedge dqs_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_r <= '0;
      wg_r <= '0;
    end else begin
      wb_r <= wb_r + 2'h1;
      wg_r <= lwpr_gray(wb_r + 2'h1);
    end
  end

  // Pointer crossing into the device clock
  logic [1:0] wg_s1_r;
  logic [1:0] wg_s2_r;
  logic [1:0] rb_r;
  logic pair_vld;
  logic [PW-1:0] pair;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end else begin
      wg_s1_r <= wg_r;
      wg_s2_r <= wg_s1_r;
    end
  end

  assign pair_vld = lwpr_gray(rb_r) != wg_s2_r;
  assign pair = cap_mem[rb_r];

  // Every arriving pair is consumed, wanted or not
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rb_r <= '0;
    end else if (pair_vld) begin
      rb_r <= rb_r + 2'h1;
    end
  end

  // Command decode
  logic [2:0] cmd;
  logic cmd_ok;
  logic ap;
  logic is_wr;
  logic is_rd;
  logic is_pre;
  logic is_act;
  logic is_ref;
  logic cut;
  logic cke_prev_r;
  lwpr_pkg::lwpr_pwr_t pwr_r;
  lwpr_pkg::lwpr_bank_t st_r [4];

  // Commands count only while running; power-down states exit on cke with cs_n high or the NOP code, self refresh on cke once its minimum time is over
  assign cmd = {ras_n, cas_n, we_n};
  assign cmd_ok = (pwr_r == lwpr_pkg::PS_RUN) && cke && !cs_n;
  assign ap = addr[lwpr_pkg::A10_BIT];
  assign is_act = cmd_ok && cmd == lwpr_pkg::CMD_ACT;
  assign is_pre = cmd_ok && cmd == lwpr_pkg::CMD_PRE;
  assign is_ref = cmd_ok && cmd == lwpr_pkg::CMD_REF && cke_prev_r;
  // Accesses to a bank without an open row are dropped
  assign is_wr = cmd_ok && cmd == lwpr_pkg::CMD_WR &&
    st_r[ba] == lwpr_pkg::BK_ACT;
  assign is_rd = cmd_ok && cmd == lwpr_pkg::CMD_RD &&
    st_r[ba] == lwpr_pkg::BK_ACT;

  // Pair schedule, slot 0 is the pair due in the current cycle
  logic [SL-1:0] sv_r;
  logic [1:0] sb_r [SL];
  logic [COL_W-1:0] sc_r [SL];
  logic [SL-1:0] sl_r;
  logic [SL-1:0] sa_r;

  // A read, or a precharge of the writing bank, cuts the burst
  assign cut = is_rd || (is_pre && (ap || ba == sb_r[0]));

  // Write loads the whole schedule; a chained write overwrites it, a cut clears it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sv_r <= '0;
      sl_r <= '0;
      sa_r <= '0;
      for (int k = 0; k < SL; k++) begin
        sb_r[k] <= '0;
        sc_r[k] <= '0;
      end
    end else begin
      for (int k = 0; k < SL; k++) begin
        if (is_wr) begin
          sv_r[k] <= 1'b1;
          sb_r[k] <= ba;
          sc_r[k] <= addr[COL_W-1:0] + COL_W'(2 * k);
          sl_r[k] <= (k == SL - 1);
          sa_r[k] <= ap && (k == SL - 1);
        end else if (cut) begin
          sv_r[k] <= 1'b0;
        end else if (k < SL - 1) begin
          sv_r[k] <= sv_r[k+1];
          sb_r[k] <= sb_r[k+1];
          sc_r[k] <= sc_r[k+1];
          sl_r[k] <= sl_r[k+1];
          sa_r[k] <= sa_r[k+1];
        end else begin
          sv_r[k] <= 1'b0;
        end
      end
    end
  end

  // Queue of due pairs waiting for their data to cross
  logic [1:0] qb_r [8];
  logic [COL_W-1:0] qc_r [8];
  logic [7:0] ql_r;
  logic [7:0] qa_r;
  logic [3:0] qw_r;
  logic [3:0] qr_r;
  logic push;
  logic pop;
  logic q_empty;

  assign push = sv_r[0] && !cut;
  assign q_empty = qw_r == qr_r;
  assign pop = pair_vld && !q_empty;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      qb_r[qw_r[2:0]] <= sb_r[0];
      qc_r[qw_r[2:0]] <= sc_r[0];
      ql_r[qw_r[2:0]] <= sl_r[0];
      qa_r[qw_r[2:0]] <= sa_r[0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      qw_r <= '0;
      qr_r <= '0;
    end else begin
      if (push) begin
        qw_r <= qw_r + 4'h1;
      end
      if (pop) begin
        qr_r <= qr_r + 4'h1;
      end
    end
  end

  // Array write port; pairs with nothing due are dropped
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arr_we <= 1'b0;
      arr_bank <= '0;
      arr_col <= '0;
      arr_data <= '0;
      arr_byte_en <= '0;
    end else begin
      arr_we <= pop;
      if (pop) begin
        arr_bank <= qb_r[qr_r[2:0]];
        arr_col <= qc_r[qr_r[2:0]];
        arr_data <= {pair[PW-DM_W-1:DQ_W+DM_W], pair[DQ_W-1:0]};
        arr_byte_en <= ~{pair[PW-1:PW-DM_W], pair[DQ_W+DM_W-1:DQ_W]};
      end
    end
  end

  // Write data pins are inputs only here
  assign dq_oe_n = 1'b1;

  // Per-bank recovery countdown and pending auto precharge
  logic [CNT_W-1:0] rec_r [4];
  logic [CNT_W-1:0] trp_r [4];
  logic [3:0] ap_pend_r;
  logic [3:0] fire;
  logic wr_done;

  assign wr_done = pop && ql_r[qr_r[2:0]];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ap_pend_r <= '0;
      for (int i = 0; i < 4; i++) begin
        rec_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_done && qb_r[qr_r[2:0]] == 2'(i)) begin
          rec_r[i] <= CNT_W'(lwpr_pkg::WR_CYC);
          ap_pend_r[i] <= qa_r[qr_r[2:0]];
        end else if (is_rd && ap && ba == 2'(i)) begin
          rec_r[i] <= CNT_W'(SL);
          ap_pend_r[i] <= 1'b1;
        end else if (fire[i]) begin
          ap_pend_r[i] <= 1'b0;
        end else if (rec_r[i] != '0) begin
          rec_r[i] <= rec_r[i] - CNT_W'(1);
        end
      end
    end
  end

  // Bank states: open, close, precharge countdown
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        st_r[i] <= lwpr_pkg::BK_RST;
        trp_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        unique case (st_r[i])
          lwpr_pkg::BK_PRE: begin
            if (trp_r[i] == '0) begin
              st_r[i] <= lwpr_pkg::BK_IDLE;
            end else begin
              trp_r[i] <= trp_r[i] - CNT_W'(1);
            end
          end
          lwpr_pkg::BK_ACT: begin
            if ((is_pre && (ap || ba == 2'(i))) || fire[i]) begin
              st_r[i] <= lwpr_pkg::BK_PRE;
              trp_r[i] <= CNT_W'(lwpr_pkg::RP_CYC - 1);
            end
          end
          lwpr_pkg::BK_IDLE: begin
            if (is_act && ba == 2'(i)) begin
              st_r[i] <= lwpr_pkg::BK_ACT;
            end
          end
          default: begin
            st_r[i] <= lwpr_pkg::BK_RST;
          end
        endcase
      end
    end
  end

  // Status per bank and the auto precharge trigger
  logic all_idle;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bank_open[i] = st_r[i] == lwpr_pkg::BK_ACT;
      bank_prechg[i] = st_r[i] == lwpr_pkg::BK_PRE;
      fire[i] = ap_pend_r[i] && rec_r[i] == '0;
    end
  end
  assign all_idle = !(|bank_open) && !(|bank_prechg);

  // Power state machine
  logic quiet;
  logic [CNT_W-1:0] sref_min_r;
  logic [CNT_W-1:0] ref_busy_r;
  logic [CNT_W-1:0] exit_r;
  logic [TMR_W-1:0] sref_tmr_r;
  logic sref_go;
  logic pdn_go;
  logic sref_tick;

  assign quiet = !(|sv_r) && q_empty && ref_busy_r == '0;
  assign sref_go = pwr_r == lwpr_pkg::PS_RUN && cke_prev_r && !cke &&
    !cs_n && cmd == lwpr_pkg::CMD_REF && all_idle;
  assign pdn_go = pwr_r == lwpr_pkg::PS_RUN && cke_prev_r && !cke &&
    !sref_go && quiet;
  assign sref_tick = pwr_r == lwpr_pkg::PS_SREF && sref_tmr_r == '0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cke_prev_r <= 1'b0;
      pwr_r <= lwpr_pkg::PS_RST;
    end else begin
      cke_prev_r <= cke;
      unique case (pwr_r)
        lwpr_pkg::PS_RUN: begin
          if (sref_go) begin
            pwr_r <= lwpr_pkg::PS_SREF;
          end else if (pdn_go) begin
            pwr_r <= all_idle ? lwpr_pkg::PS_PDP : lwpr_pkg::PS_PDA;
          end
        end
        lwpr_pkg::PS_SREF: begin
          if (cke && sref_min_r == '0) begin
            pwr_r <= lwpr_pkg::PS_RUN;
          end
        end
        lwpr_pkg::PS_PDP, lwpr_pkg::PS_PDA: begin
          if (cke && (cs_n || cmd == lwpr_pkg::CMD_NOP)) begin
            pwr_r <= lwpr_pkg::PS_RUN;
          end
        end
        default: begin
          pwr_r <= lwpr_pkg::PS_RST;
        end
      endcase
    end
  end

  // Refresh busy, self refresh minimum, internal timer, exit delay
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_busy_r <= '0;
      sref_min_r <= '0;
      sref_tmr_r <= '0;
      exit_r <= '0;
    end else begin
      if (is_ref) begin
        ref_busy_r <= CNT_W'(lwpr_pkg::RFC_CYC);
      end else if (ref_busy_r != '0) begin
        ref_busy_r <= ref_busy_r - CNT_W'(1);
      end
      if (sref_go) begin
        sref_min_r <= CNT_W'(lwpr_pkg::RFC_CYC);
        sref_tmr_r <= TMR_W'(REFI_CYC - 1);
      end else if (pwr_r == lwpr_pkg::PS_SREF) begin
        if (sref_min_r != '0) begin
          sref_min_r <= sref_min_r - CNT_W'(1);
        end
        sref_tmr_r <= sref_tick ? TMR_W'(REFI_CYC - 1) :
          sref_tmr_r - TMR_W'(1);
      end
      if (pwr_r == lwpr_pkg::PS_SREF && cke && sref_min_r == '0) begin
        exit_r <= CNT_W'(lwpr_pkg::XS_CYC);
      end else if ((pdn_pre || pdn_act) && cke &&
          (cs_n || cmd == lwpr_pkg::CMD_NOP)) begin
        exit_r <= CNT_W'(lwpr_pkg::XP_CYC);
      end else if (exit_r != '0) begin
        exit_r <= exit_r - CNT_W'(1);
      end
    end
  end

  // Internal refresh row counter, stepped by auto or self refresh
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_pulse <= 1'b0;
      ref_row <= '0;
    end else begin
      ref_pulse <= is_ref || sref_tick;
      if (is_ref || sref_tick) begin
        ref_row <= ref_row + ROW_W'(1);
      end
    end
  end

  // Power status outputs
  assign in_sref = pwr_r == lwpr_pkg::PS_SREF;
  assign pdn_pre = pwr_r == lwpr_pkg::PS_PDP;
  assign pdn_act = pwr_r == lwpr_pkg::PS_PDA;
  assign in_buf_en = pwr_r == lwpr_pkg::PS_RUN;
  assign int_clk_en = !in_sref;
  assign exit_busy = exit_r != '0;

  // Checks on bank 0 and the power, refresh and data paths
  sequence s_pdn_req;
    pwr_r == lwpr_pkg::PS_RUN && cke_prev_r && !cke && quiet;
  endsequence
  sequence s_pdn_ok;
    !(cs_n == 1'b0 && cmd == lwpr_pkg::CMD_REF && all_idle);
  endsequence

  a_pre_closes: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_pre && (ap || ba == 2'h0) && st_r[0] == lwpr_pkg::BK_ACT |=>
    st_r[0] == lwpr_pkg::BK_PRE)
    else $error("precharge did not close bank 0");
  a_pre_nop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_pre && st_r[0] == lwpr_pkg::BK_IDLE && !is_act |=>
    st_r[0] == lwpr_pkg::BK_IDLE)
    else $error("precharge of idle bank changed it");
  a_trp_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_r[0] == lwpr_pkg::BK_PRE) |-> ##RP_A
    st_r[0] == lwpr_pkg::BK_IDLE && $past(bank_prechg[0]))
    else $error("bank 0 precharge time wrong");
  a_auto_pre: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fire[0] && st_r[0] == lwpr_pkg::BK_ACT |=>
    st_r[0] == lwpr_pkg::BK_PRE && !ap_pend_r[0])
    else $error("auto precharge not started");
  a_pair_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pop |=> arr_we && arr_byte_en ==
    ~{$past(pair[PW-1:PW-DM_W]), $past(pair[DQ_W+DM_W-1:DQ_W])})
    else $error("pair not written with its mask");
  a_stray_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pair_vld && q_empty |=> !arr_we)
    else $error("stray pair reached the array");
  a_cut_burst: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_rd |=> sv_r == '0)
    else $error("read did not cut the write");
  a_sref_min: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sref_go |=> in_sref && !int_clk_en [*2])
    else $error("self refresh left too early");
  a_pdn_enter: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_pdn_req and s_pdn_ok |=> (pdn_pre == $past(all_idle)) &&
    (pdn_act != $past(all_idle)) && !in_buf_en)
    else $error("power-down entry wrong");
  a_pdn_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pdn_pre && cke && (cs_n || cmd == lwpr_pkg::CMD_NOP) |=>
    in_buf_en ##0 exit_busy)
    else $error("power-down exit wrong");
  a_ref_row: assert property (@(posedge clk_sys) disable iff (!rst_n)
    is_ref |=> ref_pulse && ref_row == $past(ref_row) + ROW_W'(1))
    else $error("refresh row did not advance");
endmodule

// ===== shared/lwpr_pkg.sv
// Constants and types shared by the LPDDR write, precharge and refresh core
package lwpr_pkg;
  // Device clock period and timing figures in their own units
  localparam int CLK_PS = 10000;
  localparam int T_RP_NS = 20;
  localparam int T_WR_NS = 15;
  localparam int T_RFC_NS = 80;
  localparam int T_XS_NS = 120;
  localparam int T_XP_NS = 10;
  localparam int REF_MS = 64;
  localparam int ROWS = 8192;
  // Least times round up to whole cycles
  localparam int RP_CYC = (T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int WR_CYC = (T_WR_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RFC_CYC = (T_RFC_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int XS_CYC = (T_XS_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int XP_CYC = (T_XP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Average refresh interval is a longest time, so it rounds down
  localparam int CYC_PER_MS = 1000000000 / CLK_PS;
  localparam int REFI_CYC = REF_MS * CYC_PER_MS / ROWS;
  localparam int BURST_LEN = 4;
  localparam int A10_BIT = 10;
  // Command codes as {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_NOP = 3'h7;
  // Bank and power states
  typedef enum logic [2:0] {
    BK_IDLE = 3'h1,
    BK_ACT = 3'h2,
    BK_PRE = 3'h4
  } lwpr_bank_t;
  typedef enum logic [3:0] {
    PS_RUN = 4'h1,
    PS_SREF = 4'h2,
    PS_PDP = 4'h4,
    PS_PDA = 4'h8
  } lwpr_pwr_t;
  // Reset values
  localparam lwpr_bank_t BK_RST = BK_IDLE;
  localparam lwpr_pwr_t PS_RST = PS_RUN;
endpackage

// ===== sim/lwpr_ctl_model.sv
// Behavioural controller write side: strobe, write data and byte masks
`timescale 1ns/10ps
module lwpr_ctl_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic slow,
  input wire logic [3:0] n_el,
  input wire logic [15:0] base,
  input wire logic [15:0] mask,
  output logic dqs_clk,
  output logic [15:0] dq_in,
  output logic [1:0] dm
);
  logic busy;
  initial begin
    dqs_clk = 1'b0;
    dq_in = 16'h5a5a;
    dm = 2'h3;
    busy = 1'b0;
  end
  // Released lines toggle each cycle so stale data never looks valid
  always @(posedge clk_sys) begin
    if (!busy) begin
      dq_in <= ~dq_in;
      dm <= ~dm;
    end
  end
  // One frame; the strobe stays still outside it
  always @(posedge clk_sys) begin
    if (go === 1'b1) begin
      busy = 1'b1;
      #(slow ? 9.5 : 4.5);
      for (int i = 0; i < n_el; i++) begin
        dq_in = base + 16'(i);
        dm = mask[2*i+:2];
        #3 dqs_clk = ~dqs_clk;
        #3 dq_in = ~dq_in;
      end
      busy = 1'b0;
    end
  end
endmodule

// ===== sim/tb_lwpr_core.sv
// Self-checking bench for the write, precharge, refresh and power core
`timescale 1ns/10ps
module tb_lwpr_core;
  logic clk_sys, rst_n, cke, cs_n, ras_n, cas_n, we_n, dqs_clk, go, slow;
  logic dq_oe_n, arr_we, ref_pulse, in_sref, pdn_pre, pdn_act;
  logic in_buf_en, int_clk_en, exit_busy;
  logic [12:0] addr, ref_row, rr;
  logic [1:0] ba, dm, arr_bank;
  logic [15:0] dq_in, base, mask;
  logic [3:0] n_el, arr_byte_en, bank_open, bank_prechg;
  logic [8:0] arr_col;
  logic [31:0] arr_data;
  logic [46:0] q[$];
  int bad_count, comparisons, cyc, ref_cnt, rc;
  lwpr_core #(.REFI_CYC(20)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .addr(addr), .ba(ba), .dqs_clk(dqs_clk), .dq_in(dq_in), .dm(dm),
    .dq_oe_n(dq_oe_n), .arr_we(arr_we), .arr_bank(arr_bank),
    .arr_col(arr_col), .arr_data(arr_data), .arr_byte_en(arr_byte_en),
    .bank_open(bank_open), .bank_prechg(bank_prechg),
    .ref_pulse(ref_pulse), .ref_row(ref_row), .in_sref(in_sref),
    .pdn_pre(pdn_pre), .pdn_act(pdn_act), .in_buf_en(in_buf_en),
    .int_clk_en(int_clk_en), .exit_busy(exit_busy));
  lwpr_ctl_model i_ctl (.clk_sys(clk_sys), .go(go), .slow(slow),
    .n_el(n_el), .base(base), .mask(mask), .dqs_clk(dqs_clk),
    .dq_in(dq_in), .dm(dm));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Collect array writes and refresh pulses; cut a hang short
  always @(posedge clk_sys) begin
    if (arr_we === 1'b1) q.push_back({arr_bank, arr_col, arr_byte_en, arr_data});
    if (ref_pulse === 1'b1) ref_cnt++;
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      $display("Error at %0t: run too long", $time);
      finish_test();
    end
  end
  // Compare a value of up to 47 bits
  task automatic chk(input logic [46:0] got, input logic [46:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Drive one command just after the edge; it is taken on the next edge
  task automatic cmd(input logic [2:0] c, input logic [1:0] b,
    input logic [12:0] a, input logic g, input logic k);
    @(posedge clk_sys);
    #1;
    {ras_n, cas_n, we_n} = c;
    cs_n = 1'b0;
    ba = b;
    addr = a;
    go = g;
    cke = k;
  endtask
  task automatic nop(input int n, input logic k);
    repeat (n) cmd(lwpr_pkg::CMD_NOP, 2'h0, 13'h0, 1'b0, k);
  endtask
  // Write command with the controller model sending n elements
  task automatic wr(input logic [1:0] b, input logic [12:0] a,
    input logic s, input logic [3:0] n);
    q.delete();
    slow = s;
    n_el = n;
    cmd(lwpr_pkg::CMD_WR, b, a, 1'b1, 1'b1);
  endtask
  // Pair k: columns c0 for the first keep pairs, then c1 onwards
  task automatic pairs(input int n, input logic [1:0] b,
    input logic [8:0] c0, input int keep, input logic [8:0] c1);
    logic [8:0] c;
    logic [15:0] d;
    chk(47'(q.size()), 47'(n));
    for (int k = 0; k < n && k < q.size(); k++) begin
      c = (k < keep) ? c0 + 9'(2*k) : c1 + 9'(2*(k-keep));
      d = base + 16'(2*k);
      chk(q[k], {b, c, ~mask[4*k+:4], d + 16'h1, d});
    end
  endtask
  task automatic t_prech();
    cmd(lwpr_pkg::CMD_ACT, 2'h0, 13'h0, 1'b0, 1'b1);
    nop(1, 1'b1);
    chk(47'(bank_open), 47'(4'h1));
    cmd(lwpr_pkg::CMD_PRE, 2'h0, 13'h0, 1'b0, 1'b1);
    nop(2, 1'b1);
    chk(47'({bank_open, bank_prechg}), 47'(8'h01));
    nop(1, 1'b1);
    chk(47'({bank_open, bank_prechg}), 47'(8'h00));
    cmd(lwpr_pkg::CMD_PRE, 2'h0, 13'h0, 1'b0, 1'b1);
    nop(1, 1'b1);
    chk(47'(bank_prechg), 47'(4'h0));
    cmd(lwpr_pkg::CMD_ACT, 2'h2, 13'h0, 1'b0, 1'b1);
    cmd(lwpr_pkg::CMD_ACT, 2'h3, 13'h0, 1'b0, 1'b1);
    cmd(lwpr_pkg::CMD_PRE, 2'h1, 13'h400, 1'b0, 1'b1);
    nop(1, 1'b1);
    chk(47'({bank_open, bank_prechg}), 47'(8'h0c));
    nop(3, 1'b1);
    $display("test precharge done");
  endtask
  task automatic t_write();
    cmd(lwpr_pkg::CMD_ACT, 2'h1, 13'h0, 1'b0, 1'b1);
    base = 16'h1230;
    mask = 16'h0004;
    wr(2'h1, 13'h004, 1'b1, 4'h6);
    nop(15, 1'b1);
    pairs(2, 2'h1, 9'h004, 2, 9'h0);
    chk(47'(dq_oe_n), 47'(1'b1));
    wr(2'h0, 13'h0, 1'b0, 4'h4);
    nop(15, 1'b1);
    chk(47'(q.size()), 47'(0));
    base = 16'h2000;
    mask = 16'h0c30;
    wr(2'h1, 13'h0, 1'b0, 4'h6);
    cmd(lwpr_pkg::CMD_WR, 2'h1, 13'h008, 1'b0, 1'b1);
    nop(15, 1'b1);
    pairs(3, 2'h1, 9'h0, 1, 9'h008);
    $display("test write done");
  endtask
  task automatic t_ap();
    logic seen;
    seen = 1'b0;
    base = 16'h3000;
    mask = 16'h0;
    wr(2'h1, 13'h402, 1'b0, 4'h4);
    repeat (20) begin
      nop(1, 1'b1);
      if (bank_prechg[1] === 1'b1) seen = 1'b1;
    end
    chk(47'(seen), 47'(1'b1));
    chk(47'({bank_open[1], bank_prechg[1]}), 47'(2'h0));
    pairs(2, 2'h1, 9'h002, 2, 9'h0);
    $display("test auto precharge done");
  endtask
  // A read, then a precharge, two cycles after the write keep one pair
  task automatic t_cut();
    for (int i = 0; i < 2; i++) begin
      cmd(lwpr_pkg::CMD_ACT, 2'h1, 13'h0, 1'b0, 1'b1);
      nop(2, 1'b1);
      base = 16'h4000 + 16'(i * 256);
      wr(2'h1, 13'h010, 1'b0, 4'h4);
      nop(1, 1'b1);
      cmd(i ? lwpr_pkg::CMD_PRE : lwpr_pkg::CMD_RD, 2'h1, 13'h0, 1'b0, 1'b1);
      nop(15, 1'b1);
      pairs(1, 2'h1, 9'h010, 1, 9'h0);
      chk(47'(bank_open[1]), 47'(i == 0));
    end
    // Full burst, then read and precharge only after recovery
    cmd(lwpr_pkg::CMD_ACT, 2'h1, 13'h0, 1'b0, 1'b1);
    nop(2, 1'b1);
    base = 16'h5000;
    mask = 16'h0;
    wr(2'h1, 13'h020, 1'b0, 4'h4);
    nop(6, 1'b1);
    cmd(lwpr_pkg::CMD_RD, 2'h1, 13'h0, 1'b0, 1'b1);
    cmd(lwpr_pkg::CMD_PRE, 2'h1, 13'h0, 1'b0, 1'b1);
    nop(8, 1'b1);
    pairs(2, 2'h1, 9'h020, 2, 9'h0);
    chk(47'({bank_open[1], bank_prechg[1]}), 47'(2'h0));
    $display("test cut done");
  endtask
  task automatic t_ref();
    rr = ref_row;
    rc = ref_cnt;
    cmd(lwpr_pkg::CMD_REF, 2'h0, 13'h0, 1'b0, 1'b1);
    nop(3, 1'b1);
    chk(47'(ref_row), 47'(rr + 13'h1));
    chk(47'(ref_cnt), 47'(rc + 1));
    nop(8, 1'b1);
    $display("test refresh done");
  endtask
  task automatic t_sref();
    rc = ref_cnt;
    cmd(lwpr_pkg::CMD_REF, 2'h0, 13'h0, 1'b0, 1'b0);
    nop(1, 1'b0);
    chk(47'({in_sref, int_clk_en, in_buf_en}), 47'(3'b100));
    cmd(lwpr_pkg::CMD_ACT, 2'h0, 13'h0, 1'b0, 1'b0);
    nop(45, 1'b0);
    chk(47'({in_sref, bank_open[0]}), 47'(2'b10));
    chk(47'(ref_cnt - rc >= 2), 47'(1'b1));
    nop(2, 1'b1);
    chk(47'({in_sref, exit_busy, int_clk_en}), 47'(3'b011));
    nop(10, 1'b1);
    chk(47'(exit_busy), 47'(1'b1));
    nop(3, 1'b1);
    chk(47'(exit_busy), 47'(1'b0));
    t_ref();
    cmd(lwpr_pkg::CMD_REF, 2'h0, 13'h0, 1'b0, 1'b0);
    nop(1, 1'b0);
    nop(4, 1'b1);
    chk(47'(in_sref), 47'(1'b1));
    nop(20, 1'b1);
    chk(47'(in_sref), 47'(1'b0));
    $display("test self refresh done");
  endtask
  task automatic t_pdn();
    cmd(lwpr_pkg::CMD_NOP, 2'h0, 13'h0, 1'b0, 1'b0);
    nop(1, 1'b0);
    chk(47'({pdn_pre, pdn_act, in_buf_en}), 47'(3'b100));
    nop(2, 1'b1);
    chk(47'({pdn_pre, exit_busy}), 47'(2'b01));
    nop(1, 1'b1);
    chk(47'(exit_busy), 47'(1'b0));
    cmd(lwpr_pkg::CMD_ACT, 2'h2, 13'h0, 1'b0, 1'b1);
    nop(2, 1'b1);
    cmd(lwpr_pkg::CMD_NOP, 2'h0, 13'h0, 1'b0, 1'b0);
    nop(1, 1'b0);
    chk(47'({pdn_pre, pdn_act, in_buf_en}), 47'(3'b010));
    cmd(lwpr_pkg::CMD_PRE, 2'h2, 13'h0, 1'b0, 1'b0);
    nop(3, 1'b0);
    chk(47'(bank_open[2]), 47'(1'b1));
    nop(2, 1'b1);
    chk(47'(pdn_act), 47'(1'b0));
    $display("test power-down done");
  endtask
  task automatic finish_test();
    $display("%0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial begin
    {rst_n, cs_n, ras_n, cas_n, we_n, cke} = 6'h1f;
    {addr, ba, go, slow, base, mask} = '0;
    n_el = 4'h4;
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    chk(47'({dq_oe_n, in_buf_en, int_clk_en, bank_open, bank_prechg}), 47'(11'h700));
    t_prech();
    t_write();
    t_ap();
    t_cut();
    t_ref();
    t_sref();
    t_pdn();
    finish_test();
  end
endmodule
